/* core/frirs_pkg.sv */
//-----------------------------------------------------------------------------
// Purpose : Constants and types for the floppy rate/input/status registers
// Assumes : Byte-wide register port, I/O addresses as printed
// Notes   : Shared by the register block and the bench
//-----------------------------------------------------------------------------
// Contract
// RQ1: Input status register is read only
// RQ2: Basic mode reads bits 0-6 as zero
// RQ3: Bit 7 is inverted media_changed or forced
// RQ4: Second mode bit 0 low for fast rates
// RQ5: rate_code echoed, hardware reset gives 250K code
// RQ6: Second mode bits 3-6 read one
// RQ7: Third mode bits 4-6 zero, reset image 02
// RQ8: Third mode bit 2 shows skip_write_shift
// RQ9: Third mode bit 3 shows transfer_request_enable
// RQ10: Writes set rate_code, reset value 10
// RQ11: Host writes zero to reserved rate bits
// RQ12: skip_write_shift stored, kept over software reset
// RQ13: density_select_pin high after hardware reset only
// RQ14: Status bytes delivered in result phase
// RQ15: termination_class encodes four completion kinds
// RQ16: positioning_complete set after seek or recalibrate
// RQ17: drive_fault_flag on recal or outward overstep
// RQ18: Bit 3 zero, side and unit reported
// RQ19: rate_code maps to rate and density pins
// RQ20: Shared address decoded by access direction
package frirs_pkg;

   // Register port geometry
   localparam int          ADDR_W          = 10;
   localparam logic [9:0]  ADDR_INPUT_RATE = 10'h3f7;
   localparam logic [9:0]  ADDR_STATUS0    = 10'h3f0;

   // Compatibility modes
   typedef enum logic [1:0] {
      FRIRS_MODE_BASIC  = 2'h0,
      FRIRS_MODE_SECOND = 2'h1,
      FRIRS_MODE_THIRD  = 2'h3
   } frirs_mode_t;

   // Rate codes
   localparam logic [1:0]  RATE_500K       = 2'h0;
   localparam logic [1:0]  RATE_300K       = 2'h1;
   localparam logic [1:0]  RATE_250K       = 2'h2;
   localparam logic [1:0]  RATE_1M         = 2'h3;
   localparam logic [1:0]  RATE_RESET      = RATE_250K;

   // Rate configuration field positions
   localparam int          CFG_RATE_LSB    = 0;
   localparam int          CFG_SKIP_BIT    = 2;

   // Input status layout fields
   localparam int          IN_CHG_BIT      = 7;
   localparam logic [7:0]  THIRD_RESET_IMG = 8'h02;

   // Termination classes of status byte 0
   localparam logic [1:0]  TERM_NORMAL     = 2'h0;
   localparam logic [1:0]  TERM_ABNORMAL   = 2'h1;
   localparam logic [1:0]  TERM_INVALID    = 2'h2;
   localparam logic [1:0]  TERM_POLLING    = 2'h3;

   // Recalibrate step limit before a fault
   localparam int          RECAL_STEP_MAX  = 80;

   // Density outputs (three pins: select and two drive density bits)
   typedef struct packed {
      logic       density_select;
      logic [1:0] drive_density;
   } frirs_dens_t;

   // Command completion report
   typedef struct packed {
      logic       done;
      logic [1:0] term_class;
      logic       positioning_cmd;
      logic       recal_cmd;
      logic       outward_overstep;
      logic       side_number;
      logic [1:0] unit_select;
   } frirs_done_t;

endpackage

/* core/frirs_regs.sv */
//-----------------------------------------------------------------------------
// Purpose : Input status / rate configuration registers and status byte 0
// Assumes : One clock, synchronous reset, inputs synchronous to sys_clk_i
// Notes   : Read data valid the cycle after the read strobe only
//-----------------------------------------------------------------------------
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps

module frirs_regs #(
   parameter int                   RECAL_STEPS = frirs_pkg::RECAL_STEP_MAX
) (
   // Clock, reset, enable
   input  wire logic               sys_clk_i,
   input  wire logic               rst_i,
   input  wire logic               clk_en_i,
   // Software reset via drive output or rate select register
   input  wire logic               soft_rst_i,
   // Register port
   input  wire logic [9:0]         addr_i,
   input  wire logic [7:0]         wdata_i,
   input  wire logic               wr_i,
   input  wire logic               rd_i,
   output logic      [7:0]         rdata_o,
   // Mode and neighbouring register bits
   input  wire frirs_pkg::frirs_mode_t mode_i,
   input  wire logic               transfer_request_enable_i,
   input  wire logic               force_chg_en_i,
   input  wire logic               force_chg_val_i,
   // Drive cable
   input  wire logic               media_changed_i,
   input  wire logic               track_zero_sense_i,
   input  wire logic               step_pulse_i,
   // Command engine report
   input  wire frirs_pkg::frirs_done_t done_i,
   // Result phase data
   output logic      [7:0]         result_status_0_o,
   output logic                    result_valid_o,
   // Drive controls
   output logic      [1:0]         rate_code_o,
   output logic                    skip_write_shift_o,
   output frirs_pkg::frirs_dens_t  dens_o
);

   //--------------------------------------------------------------------------
   // State
   //--------------------------------------------------------------------------
   logic [1:0]             rate_code_q;
   logic                   skip_q;
   logic [7:0]             rdata_q;
   logic [7:0]             status0_q;
   logic                   result_valid_q;
   logic                   dens_pin_q;
   logic [1:0]             drive_den_q;
   logic [7:0]             recal_cnt_q;
   logic                   recal_fault_q;
   logic                   low_density_indicator;
   logic                   chg_bit;
   logic [7:0]             input_image;

   // Slow rates give the low-density indication
   function automatic logic slow_rate(input logic [1:0] rc);
      return (rc == frirs_pkg::RATE_250K) || (rc == frirs_pkg::RATE_300K);
   endfunction

   // Density pin follows the rate: high for 500K and 1M
   function automatic logic dens_of(input logic [1:0] rc);
      return !slow_rate(rc);
   endfunction

   //--------------------------------------------------------------------------
   // Rate configuration register, write only at the shared address
   //--------------------------------------------------------------------------
   // Software reset leaves both fields alone, so it does not appear here
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rate_code_q <= frirs_pkg::RATE_RESET; // RQ5 RQ10
      end else if (clk_en_i && wr_i &&
                   addr_i == frirs_pkg::ADDR_INPUT_RATE) begin // RQ20
         rate_code_q <= wdata_i[frirs_pkg::CFG_RATE_LSB +: 2]; // RQ10
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         skip_q <= 1'b0;
      end else if (clk_en_i && wr_i &&
                   addr_i == frirs_pkg::ADDR_INPUT_RATE &&
                   mode_i == frirs_pkg::FRIRS_MODE_THIRD) begin
         // Host keeps upper bits zero; they are not stored anyway
         skip_q <= wdata_i[frirs_pkg::CFG_SKIP_BIT]; // RQ12 RQ11
      end
   end

   //--------------------------------------------------------------------------
   // Input status image, three layouts
   //--------------------------------------------------------------------------
   assign low_density_indicator = slow_rate(rate_code_q); // RQ4
   assign chg_bit = force_chg_en_i ? force_chg_val_i
                                   : !media_changed_i; // RQ3

   always_comb begin
      input_image = 8'h00; // RQ2
      unique case (mode_i)
         frirs_pkg::FRIRS_MODE_BASIC: begin
            input_image = 8'h00; // RQ2
         end
         frirs_pkg::FRIRS_MODE_SECOND: begin
            input_image[6:3] = 4'hf; // RQ6
            input_image[2:1] = rate_code_q; // RQ5
            input_image[0]   = low_density_indicator; // RQ4
         end
         frirs_pkg::FRIRS_MODE_THIRD: begin
            input_image[6:4] = 3'h0; // RQ7
            input_image[3]   = transfer_request_enable_i; // RQ9
            input_image[2]   = skip_q; // RQ8
            input_image[1:0] = rate_code_q; // RQ5 RQ7
         end
         default: begin
            input_image = 8'h00;
         end
      endcase
      input_image[frirs_pkg::IN_CHG_BIT] = chg_bit; // RQ3
   end

   //--------------------------------------------------------------------------
   // Read port: writes never touch the input image
   //--------------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (clk_en_i) begin
         if (rd_i && addr_i == frirs_pkg::ADDR_INPUT_RATE) begin
            rdata_q <= input_image; // RQ1 RQ20
         end else if (rd_i && addr_i == frirs_pkg::ADDR_STATUS0) begin
            rdata_q <= status0_q; // RQ14
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   //--------------------------------------------------------------------------
   // Recalibrate step counter for the equipment check
   //--------------------------------------------------------------------------
   // Counts step pulses while track zero is not seen; saturates at the limit
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || soft_rst_i) begin
         recal_cnt_q   <= 8'h00;
         recal_fault_q <= 1'b0;
      end else if (clk_en_i) begin
         if (done_i.done || track_zero_sense_i) begin
            recal_cnt_q   <= 8'h00;
            recal_fault_q <= 1'b0;
         end else if (step_pulse_i && !recal_fault_q) begin
            if (recal_cnt_q == 8'(RECAL_STEPS - 1)) begin
               recal_fault_q <= 1'b1; // RQ17
            end
            recal_cnt_q <= recal_cnt_q + 8'h01;
         end
      end
   end

   //--------------------------------------------------------------------------
   // Status byte 0, captured at command completion
   //--------------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || soft_rst_i) begin
         status0_q      <= 8'h00;
         result_valid_q <= 1'b0;
      end else if (clk_en_i) begin
         if (done_i.done) begin
            status0_q[7:6] <= done_i.term_class; // RQ15
            status0_q[5]   <= done_i.positioning_cmd; // RQ16
            status0_q[4]   <= (done_i.recal_cmd && recal_fault_q &&
                               !track_zero_sense_i) ||
                              done_i.outward_overstep; // RQ17
            status0_q[3]   <= 1'b0; // RQ18
            status0_q[2]   <= done_i.side_number; // RQ18
            status0_q[1:0] <= done_i.unit_select; // RQ18
            result_valid_q <= 1'b1; // RQ14
         end else if (rd_i && addr_i == frirs_pkg::ADDR_STATUS0) begin
            result_valid_q <= 1'b0;
         end
      end
   end

   //--------------------------------------------------------------------------
   // Density outputs
   //--------------------------------------------------------------------------
   // Only the hardware reset forces the pin; software resets leave it be
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         dens_pin_q  <= 1'b1; // RQ13
         drive_den_q <= frirs_pkg::RATE_RESET;
      end else if (clk_en_i) begin
         dens_pin_q  <= dens_of(rate_code_q); // RQ19
         drive_den_q <= rate_code_q; // RQ19
      end
   end

   assign rdata_o             = rdata_q;
   assign result_status_0_o   = status0_q;
   assign result_valid_o      = result_valid_q;
   assign rate_code_o         = rate_code_q;
   assign skip_write_shift_o  = skip_q;
   // One driver for the whole struct; per-field assigns split the variable
   assign dens_o                = {dens_pin_q, drive_den_q};

endmodule

/* testbench/frirs_regs_monitor.sv */
// Purpose : Port checker for frirs_regs
// Assumes : One clock, synchronous active-high reset
// Notes   : Read images are judged at the strobe edge inputs
`timescale 1ns/1ps
module frirs_regs_monitor #(
   parameter int RECAL_STEPS = 80
) (
   input wire logic sys_clk_i, rst_i, clk_en_i, soft_rst_i, wr_i, rd_i,
   input wire logic [9:0] addr_i,
   input wire logic [7:0] wdata_i, rdata_o, result_status_0_o,
   input wire frirs_pkg::frirs_mode_t mode_i,
   input wire logic transfer_request_enable_i, force_chg_en_i,
   input wire logic force_chg_val_i, media_changed_i, track_zero_sense_i,
   input wire logic step_pulse_i, result_valid_o, skip_write_shift_o,
   input wire frirs_pkg::frirs_done_t done_i,
   input wire logic [1:0] rate_code_o,
   input wire frirs_pkg::frirs_dens_t dens_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic rd_a;
   logic wr_a;
   logic b7;
   assign rd_a = rd_i && clk_en_i && addr_i == frirs_pkg::ADDR_INPUT_RATE;
   assign wr_a = wr_i && clk_en_i && addr_i == frirs_pkg::ADDR_INPUT_RATE;
   assign b7 = force_chg_en_i ? force_chg_val_i : !media_changed_i;
   property p_basic;
      rd_a && mode_i == frirs_pkg::FRIRS_MODE_BASIC |=>
         rdata_o == {$past(b7), 7'h00};
   endproperty
   a_basic: assert property (p_basic)
      else $error("basic image wrong");
   property p_second;
      rd_a && mode_i == frirs_pkg::FRIRS_MODE_SECOND |=> rdata_o ==
         {$past(b7), 4'hf, $past(rate_code_o), ^$past(rate_code_o)};
   endproperty
   a_second: assert property (p_second)
      else $error("second image wrong");
   property p_third;
      rd_a && mode_i == frirs_pkg::FRIRS_MODE_THIRD |=> rdata_o ==
         {$past(b7), 3'h0, $past(transfer_request_enable_i),
          $past(skip_write_shift_o), $past(rate_code_o)};
   endproperty
   a_third: assert property (p_third)
      else $error("third image wrong");
   property p_rate_wr;
      wr_a |=> rate_code_o == $past(wdata_i[1:0]);
   endproperty
   a_rate_wr: assert property (p_rate_wr)
      else $error("rate not written");
   property p_rate_hold;
      !wr_a |=> $stable(rate_code_o);
   endproperty
   a_rate_hold: assert property (p_rate_hold)
      else $error("rate changed");
   property p_skip;
      wr_a |=> skip_write_shift_o == ($past(mode_i) ==
         frirs_pkg::FRIRS_MODE_THIRD ? $past(wdata_i[2]) :
         $past(skip_write_shift_o));
   endproperty
   a_skip: assert property (p_skip)
      else $error("skip flag wrong");
   property p_dens;
      wr_a ##1 clk_en_i |=> dens_o == {$past(rate_code_o[1]) ==
         $past(rate_code_o[0]), $past(rate_code_o)};
   endproperty
   a_dens: assert property (p_dens)
      else $error("density pins wrong");
   property p_stat;
      done_i.done && clk_en_i |=> result_valid_o &&
         result_status_0_o[7:5] == $past({done_i.term_class,
         done_i.positioning_cmd});
   endproperty
   a_stat: assert property (p_stat)
      else $error("status class wrong");
   property p_stat_lo;
      done_i.done && clk_en_i |=> result_status_0_o[3:0] ==
         {1'b0, $past(done_i.side_number), $past(done_i.unit_select)};
   endproperty
   a_stat_lo: assert property (p_stat_lo)
      else $error("status low bits wrong");
   property p_over;
      done_i.done && done_i.outward_overstep && clk_en_i |=>
         result_status_0_o[4];
   endproperty
   a_over: assert property (p_over)
      else $error("fault bit missing");
   property p_clr;
      rd_i && clk_en_i && !done_i.done &&
         addr_i == frirs_pkg::ADDR_STATUS0 |=> !result_valid_o;
   endproperty
   a_clr: assert property (p_clr)
      else $error("result valid kept");
   c_third: cover property (rd_a && mode_i == frirs_pkg::FRIRS_MODE_THIRD);
   c_done: cover property (done_i.done ##2 rd_i);
   c_wr: cover property (wr_a ##2 wr_a);
endmodule

bind frirs_regs frirs_regs_monitor #(.RECAL_STEPS(RECAL_STEPS)) i_mon (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
   .soft_rst_i(soft_rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .rdata_o(rdata_o), .mode_i(mode_i),
   .result_status_0_o(result_status_0_o), .done_i(done_i),
   .transfer_request_enable_i(transfer_request_enable_i),
   .force_chg_en_i(force_chg_en_i), .force_chg_val_i(force_chg_val_i),
   .media_changed_i(media_changed_i), .step_pulse_i(step_pulse_i),
   .track_zero_sense_i(track_zero_sense_i), .dens_o(dens_o),
   .result_valid_o(result_valid_o), .rate_code_o(rate_code_o),
   .skip_write_shift_o(skip_write_shift_o));

/* testbench/frirs_drive_model.sv */
// Purpose : Drive cable: head stepping and track zero sensor
// Assumes : Steps are one-cycle pulses, one every other cycle
// Notes   : stuck_i hides track zero, like a dead sensor
`timescale 1ns/1ps
module frirs_drive_model #(
   parameter int START_TRACK = 2
) (
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic step_req_i,
   input  wire logic stuck_i,
   output logic      step_o,
   output logic      track_zero_o
);
   int track_q;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         track_q <= START_TRACK;
         step_o <= 1'b0;
      end else begin
         step_o <= step_req_i && !step_o;
         if (step_o && track_q > 0) track_q <= track_q - 1;
      end
   end
   assign track_zero_o = (track_q == 0) && !stuck_i;
endmodule

/* testbench/frirs_regs_test.sv */
// Purpose : Register-port tests of frirs_regs
// Assumes : Recalibrate limit shortened to 4 steps
// Notes   : Reads check rdata the cycle after the strobe
`timescale 1ns/1ps
module frirs_regs_test;
   logic sys_clk_i = 0, rst_i = 1, clk_en_i = 1, soft_rst_i = 0;
   logic wr_i = 0, rd_i = 0, tre = 0, f_en = 0, f_val = 0, media = 0;
   logic step_req = 0, stuck = 0, step, track_zero_sense, valid, skip, b7;
   logic [9:0] addr_i = '0;
   logic [7:0] wdata_i = '0, rdata_o, stat;
   logic [1:0] rate;
   frirs_pkg::frirs_mode_t mode_i = frirs_pkg::FRIRS_MODE_THIRD;
   frirs_pkg::frirs_done_t done_i = '0;
   frirs_pkg::frirs_dens_t dens_o;
   int n_mismatch = 0, comparisons = 0, cycles = 0;
   localparam logic [9:0] A = frirs_pkg::ADDR_INPUT_RATE;
   always #50 sys_clk_i = ~sys_clk_i;
   frirs_regs #(.RECAL_STEPS(4)) i_frirs_regs (.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .clk_en_i(clk_en_i), .soft_rst_i(soft_rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .mode_i(mode_i), .transfer_request_enable_i(tre),
      .force_chg_en_i(f_en), .force_chg_val_i(f_val), .done_i(done_i),
      .media_changed_i(media), .track_zero_sense_i(track_zero_sense),
      .step_pulse_i(step), .result_status_0_o(stat), .dens_o(dens_o),
      .result_valid_o(valid), .rate_code_o(rate), .skip_write_shift_o(skip));
   frirs_drive_model i_frirs_drive_model (.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .step_req_i(step_req), .stuck_i(stuck),
      .step_o(step), .track_zero_o(track_zero_sense));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task end_sim;
      if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr_i <= 1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 0;
   endtask
   task rd(input logic [9:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      rd_i <= 1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 0;
      #1 chk(rdata_o, e);
   endtask
   task fin(input frirs_pkg::frirs_done_t d, input logic [7:0] e);
      @(posedge sys_clk_i);
      done_i <= d;
      @(posedge sys_clk_i);
      done_i <= '0;
      #1 chk({7'h0, valid}, 8'h01);
      rd(frirs_pkg::ADDR_STATUS0, e);
      #1 chk({7'h0, valid}, 8'h00);
   endtask
   task pulse_soft;
      @(posedge sys_clk_i);
      soft_rst_i <= 1;
      @(posedge sys_clk_i);
      soft_rst_i <= 0;
   endtask
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 0;
      #1 chk({5'h0, dens_o.density_select, rate}, 8'h06);
      rd(A, 8'h82);
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk_i);
         media <= i[0];
         f_en <= i[2];
         f_val <= i[1];
         tre <= i[1];
         mode_i <= frirs_pkg::FRIRS_MODE_THIRD;
         wr(A, {5'h0, i[2], i[1:0]});
         b7 = f_en ? f_val : ~media;
         rd(A, {b7, 3'h0, tre, i[2], i[1:0]});
         chk({5'h0, dens_o}, {5'h0, i[1] == i[0], i[1:0]});
         mode_i <= frirs_pkg::FRIRS_MODE_SECOND;
         rd(A, {b7, 4'hf, i[1:0], ^i[1:0]});
         mode_i <= frirs_pkg::FRIRS_MODE_BASIC;
         rd(A, {b7, 7'h00});
      end
      wr(A, 8'h01);
      mode_i <= frirs_pkg::FRIRS_MODE_THIRD;
      pulse_soft();
      rd(A, 8'h8d);
      chk({5'h0, dens_o}, 8'h01);
      wr(frirs_pkg::ADDR_STATUS0, 8'hff);
      rd(10'h3f1, 8'h00);
      rd(A, 8'h8d);
      // A write while the enable is low must be lost
      clk_en_i <= 0;
      wr(A, 8'h02);
      clk_en_i <= 1;
      rd(A, 8'h8d);
      wr(A, 8'h02);
      wr(A, 8'h03);
      rd(A, 8'h8b);
      stuck <= 1;
      step_req <= 1;
      // Exactly the shortened limit of step pulses, no spare one
      repeat (8) @(posedge sys_clk_i);
      step_req <= 0;
      fin({1'b1, 2'h1, 1'b1, 1'b1, 1'b0, 1'b1, 2'h2}, 8'h76);
      pulse_soft();
      stuck <= 0;
      for (int t = 0; t < 4; t++)
         fin({1'b1, t[1:0], t[0], t[0], t == 3, t[1], ~t[1:0]},
             {t[1:0], t[0], t == 3, 1'b0, t[1], ~t[1:0]});
      end_sim();
   end
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         end_sim();
      end
   end
endmodule
